// ===== core/rx_part_defines.svh
// register indices, field layout, reset values and depth bases for the
// receive bank shaping block; included by the package and the top module
`ifndef RX_PART_DEFINES_SVH
`define RX_PART_DEFINES_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define IDX_CNT_CORE_A    18'h3_0906
`define IDX_WID_CORE_A    18'h3_0907
`define IDX_STAT_CORE_A   18'h3_0908
`define IDX_CNT_CORE_B    18'h3_0a06
`define IDX_WID_CORE_B    18'h3_0a07
`define IDX_STAT_CORE_B   18'h3_0a08

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define BANK_FIELD_W      2
`define STAT_OK_BIT       0
`define CFG_RESET         8'h00

// ----------------------------------------
// depths in bytes for 32-bit mode, one partition
// ----------------------------------------
`define DATA_DEPTH_BASE   14'h0800
`define CTRL_DEPTH_BASE   12'h0200

`endif

// ===== core/rx_part_pkg.sv
// types and shared arithmetic for the receive bank shaping block
// assumes rx_part_defines.svh is on the include path
package rx_part_pkg;
	`include "rx_part_defines.svh"

	typedef enum logic [1:0] {
		WIDTH_32,
		WIDTH_64,
		WIDTH_128,
		WIDTH_RSVD
	} width_mode_type;

	typedef struct packed {
		logic           valid;
		width_mode_type width;
		logic [1:0]     count;
		logic [13:0]    data_depth;
		logic [11:0]    ctrl_depth;
		logic [2:0]     fifo_sel;
	} bank_shape_type;

	// wider bank doubles, more partitions halve
	function automatic logic [13:0] depth_scale(input logic [13:0] base,
		input logic [1:0] w, input logic [1:0] c);
		logic [15:0] t;
		t = {2'b00, base} << w;
		t = t >> c;
		return t[13:0];
	endfunction : depth_scale
endpackage : rx_part_pkg

// ===== core/bank_shape_decode.sv
// decodes one bank's width and partition-count fields into its shape
// assumes the fields come from registers; purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "rx_part_defines.svh"
module bank_shape_decode
	import rx_part_pkg::*;
(
	// configuration fields
	input  wire logic [1:0] width_code,
	input  wire logic [1:0] count_code,
	// fabric side
	input  wire logic [2:0] fifo_addr,
	// result
	output var bank_shape_type shape
);
	always_comb begin
		shape.valid = (width_code != 2'b11); // RULE1
		shape.width = width_mode_type'(width_code); // RULE1
		shape.count = count_code; // RULE2
		shape.data_depth = 14'h0000;
		shape.ctrl_depth = 12'h000;
		if (shape.valid) begin
			shape.data_depth = depth_scale(`DATA_DEPTH_BASE, width_code, count_code); // RULE9
			shape.ctrl_depth = 12'(depth_scale({2'b00, `CTRL_DEPTH_BASE}, width_code,
				count_code)); // RULE9
		end
		// address bits beyond the partition count are dropped
		case (count_code)
			2'b00: shape.fifo_sel = 3'b000; // RULE8
			2'b01: shape.fifo_sel = {2'b00, fifo_addr[0]}; // RULE8
			2'b10: shape.fifo_sel = {1'b0, fifo_addr[1:0]}; // RULE8
			default: shape.fifo_sel = fifo_addr; // RULE8
		endcase
	end
endmodule : bank_shape_decode
`default_nettype wire

// ===== core/rx_buffer_partition_config.sv
// receive bank shaping registers for both interface cores, with an
// Avalon-MM slave; assumes a synchronous master on core_clk
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "rx_part_defines.svh"

// Functional notes
// RULE1: width field 00 gives 32-bit, 01 64-bit, 10 128-bit bank.
// RULE2: count field 00/01/10/11 gives 1/2/4/8 equal virtual FIFOs.
// RULE3: bank 0 field in bits 1:0, bank 1 in bits 3:2, independent.
// RULE4: bank 2 field in bits 5:4, bank 3 in bits 7:6.
// RULE5: count register uses the same bit positions, bank 0 in 1:0.
// RULE6: each core has its own width and count registers.
// RULE7: software pairs banks identically in 64-bit and 128-bit modes.
// RULE8: fifo read address picks partition; ignored with one partition.
// RULE9: depths double per width step and halve per count doubling.
module rx_buffer_partition_config
	import rx_part_pkg::*;
(
	// clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       rst_b,
	// avalon-mm slave
	input  wire logic [19:0]                address,
	input  wire logic                       read,
	input  wire logic                       write,
	input  wire logic [31:0]                writedata,
	input  wire logic [3:0]                 byteenable,
	output logic      [31:0]                readdata,
	output logic                            waitrequest,
	// fabric read addresses, per core and bank
	input  wire logic [1:0][3:0][2:0]       fifo_addr,
	// bank shapes and pairing check, per core
	output var bank_shape_type [1:0][3:0]   bank_shape,
	output logic      [1:0]                 cfg_ok
);
	typedef struct packed {
		logic                      waitreq;
		logic [31:0]               rdata;
		logic [1:0][7:0]           width;
		logic [1:0][7:0]           count;
		bank_shape_type [1:0][3:0] shape;
		logic [1:0]                ok;
	} cfg_state_type;

	cfg_state_type             state_r;
	cfg_state_type             state_nxt;
	bank_shape_type [1:0][3:0] dec_shape;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic mode_ok(input logic [7:0] w, input logic [7:0] c);
		logic ok;
		ok = 1'b1;
		if (w[1:0] == 2'b10 || w[3:2] == 2'b10 || w[5:4] == 2'b10 || w[7:6] == 2'b10) begin
			ok = (w == 8'haa) && (c == {4{c[1:0]}});
		end else begin
			if (w[1:0] == 2'b01 || w[3:2] == 2'b01) begin
				ok = ok && (w[3:0] == 4'h5) && (c[3:2] == c[1:0]);
			end
			if (w[5:4] == 2'b01 || w[7:6] == 2'b01) begin
				ok = ok && (w[7:4] == 4'h5) && (c[7:6] == c[5:4]);
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (w[2*i +: 2] == 2'b11) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : mode_ok

	function automatic logic [31:0] read_value(input logic [19:0] a, input cfg_state_type s);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a[19:2] == `IDX_CNT_CORE_A) begin
			v[7:0] = s.count[0];
		end else if (a[19:2] == `IDX_WID_CORE_A) begin
			v[7:0] = s.width[0];
		end else if (a[19:2] == `IDX_STAT_CORE_A) begin
			v[`STAT_OK_BIT] = s.ok[0];
		end else if (a[19:2] == `IDX_CNT_CORE_B) begin
			v[7:0] = s.count[1];
		end else if (a[19:2] == `IDX_WID_CORE_B) begin
			v[7:0] = s.width[1];
		end else if (a[19:2] == `IDX_STAT_CORE_B) begin
			v[`STAT_OK_BIT] = s.ok[1];
		end
		return v;
	endfunction : read_value

	// ----------------------------------------
	// per-bank decoders
	// ----------------------------------------
	for (genvar c = 0; c < 2; c++) begin : g_core
		for (genvar b = 0; b < 4; b++) begin : g_bank
			bank_shape_decode i_bank_shape_decode (
				.width_code (state_r.width[c][2*b +: `BANK_FIELD_W]), // RULE3 RULE4
				.count_code (state_r.count[c][2*b +: `BANK_FIELD_W]), // RULE5
				.fifo_addr  (fifo_addr[c][b]),
				.shape      (dec_shape[c][b])
			);
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// two-cycle answer: waitrequest drops one edge after the request,
	// and the write lands on the edge that sees it low
	always_comb begin
		state_nxt = state_r;
		state_nxt.shape = dec_shape;
		for (int c = 0; c < 2; c++) begin
			state_nxt.ok[c] = mode_ok(state_r.width[c], state_r.count[c]);
		end
		if ((read || write) && state_r.waitreq) begin
			state_nxt.waitreq = 1'b0;
			state_nxt.rdata = read ? read_value(address, state_r) : 32'h0000_0000;
		end else begin
			state_nxt.waitreq = 1'b1;
		end
		if (write && !state_r.waitreq && byteenable[0]) begin
			if (address[19:2] == `IDX_CNT_CORE_A) begin
				state_nxt.count[0] = writedata[7:0]; // RULE6
			end else if (address[19:2] == `IDX_WID_CORE_A) begin
				state_nxt.width[0] = writedata[7:0]; // RULE6
			end else if (address[19:2] == `IDX_CNT_CORE_B) begin
				state_nxt.count[1] = writedata[7:0]; // RULE6
			end else if (address[19:2] == `IDX_WID_CORE_B) begin
				state_nxt.width[1] = writedata[7:0]; // RULE6
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_r <= '0;
			state_r.waitreq <= 1'b1;
			state_r.width <= {2{`CFG_RESET}};
			state_r.count <= {2{`CFG_RESET}};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign readdata    = state_r.rdata;
	assign waitrequest = state_r.waitreq;
	assign bank_shape  = state_r.shape;
	assign cfg_ok      = state_r.ok;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_write_wid_b;
		write && !waitrequest && byteenable[0] && address[19:2] == `IDX_WID_CORE_B;
	endsequence

	sequence s_request_open;
		(read || write) && waitrequest;
	endsequence

	property p_width_map;
		$past(state_r.width[0][1:0]) == 2'b01 |-> bank_shape[0][0].width == WIDTH_64;
	endproperty
	a_width_map: assert property (p_width_map) else $error("bank 0 width decode wrong"); // RULE1

	property p_count_eight;
		$past(state_r.count[0][1:0]) == 2'b11 && $past(state_r.width[0][1:0]) == 2'b00
			|-> bank_shape[0][0].data_depth == 14'h0100;
	endproperty
	a_count_eight: assert property (p_count_eight) else $error("eight-way depth wrong"); // RULE2

	property p_bank1_field;
		bank_shape[0][1].count == $past(state_r.count[0][3:2]);
	endproperty
	a_bank1_field: assert property (p_bank1_field) else $error("bank 1 field misplaced"); // RULE3

	property p_bank3_field;
		bank_shape[1][3].width == width_mode_type'($past(state_r.width[1][7:6]));
	endproperty
	a_bank3_field: assert property (p_bank3_field) else $error("bank 3 field misplaced"); // RULE4

	property p_count_bank0;
		bank_shape[1][0].count == $past(state_r.count[1][1:0]);
	endproperty
	a_count_bank0: assert property (p_count_bank0) else $error("count bank 0 misplaced"); // RULE5

	property p_core_split;
		s_write_wid_b |=> state_r.width[1] == $past(writedata[7:0])
			&& state_r.width[0] == $past(state_r.width[0]);
	endproperty
	a_core_split: assert property (p_core_split) else $error("core b write leaked"); // RULE6

	property p_single_ignores;
		$past(state_r.count[0][1:0]) == 2'b00 |-> bank_shape[0][0].fifo_sel == 3'b000;
	endproperty
	a_single_ignores: assert property (p_single_ignores) else $error("single fifo not zero"); // RULE8

	property p_depth_ratio;
		bank_shape[0][0].valid |-> bank_shape[0][0].data_depth
			== {bank_shape[0][0].ctrl_depth, 2'b00};
	endproperty
	a_depth_ratio: assert property (p_depth_ratio) else $error("depth ratio broken"); // RULE9

	property p_answer;
		s_request_open |=> !waitrequest ##1 waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer timing wrong");

	property p_two_way_sel;
		$past(state_r.count[1][5:4]) == 2'b01
			|-> bank_shape[1][2].fifo_sel == {2'b00, $past(fifo_addr[1][2][0])};
	endproperty
	a_two_way_sel: assert property (p_two_way_sel) else $error("two-way select wrong"); // RULE8

	property p_reserved_code;
		$past(state_r.width[0][1:0]) == 2'b11 |-> !bank_shape[0][0].valid
			&& bank_shape[0][0].data_depth == 14'h0000;
	endproperty
	a_reserved_code: assert property (p_reserved_code) else $error("reserved width kept"); // RULE1
endmodule : rx_buffer_partition_config
`default_nettype wire

// ===== tb/rx_buffer_partition_config_tb.sv
// self-checking bench for the receive bank shaping registers
// assumes the package and design files are compiled before this one
`timescale 1ns/10ps
`default_nettype none
module rx_buffer_partition_config_tb
	import rx_part_pkg::*;
;
	logic                      core_clk;
	logic                      rst_b;
	logic [19:0]               address;
	logic                      read;
	logic                      write;
	logic [31:0]               writedata;
	logic [3:0]                byteenable;
	logic [31:0]               readdata;
	logic                      waitrequest;
	logic [1:0][3:0][2:0]      fifo_addr;
	bank_shape_type [1:0][3:0] bank_shape;
	logic [1:0]                cfg_ok;
	logic [31:0]               q;
	logic [17:0]               regs [4];
	int                        fail_count;
	int                        num_checks;

	rx_buffer_partition_config i_rx_buffer_partition_config (
		.core_clk(core_clk), .rst_b(rst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .fifo_addr(fifo_addr),
		.bank_shape(bank_shape), .cfg_ok(cfg_ok));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one avalon transfer; junk in the upper data bytes must never stick
	task automatic bus(input logic wr, input logic [17:0] idx, input logic [7:0] d,
		input logic be0);
		int n;
		address    <= {idx, 2'b00};
		read       <= ~wr;
		write      <= wr;
		writedata  <= {24'ha5_a5a5, d};
		byteenable <= {3'h7, be0};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 64);
		q = readdata;
		read  <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0) begin
			fail_count++;
			tally_and_finish();
		end
		@(posedge core_clk);
	endtask : bus

	task automatic rchk(input logic [17:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00, 1'b1);
		chk(64'(q), 64'(exp));
	endtask : rchk

	// shape and pairing flag follow the store one edge later
	task automatic settle;
		repeat (2) @(posedge core_clk);
	endtask : settle

	task automatic shp(input int k, input int b, input logic [1:0] w, input logic [1:0] c);
		bank_shape_type e;
		e.valid      = 1'b1;
		e.width      = width_mode_type'(w);
		e.count      = c;
		e.data_depth = (14'h0800 << w) >> c;
		e.ctrl_depth = (12'h0200 << w) >> c;
		e.fifo_sel   = fifo_addr[k][b] & 3'((4'h1 << c) - 4'h1);
		chk(64'(bank_shape[k][b]), 64'(e));
	endtask : shp

	initial begin
		rst_b      = 1'b0;
		address    = 20'h0_0000;
		read       = 1'b0;
		write      = 1'b0;
		writedata  = 32'h0000_0000;
		byteenable = 4'h0;
		fifo_addr  = {8{3'h7}};
		q          = 32'h0000_0000;
		regs       = '{18'h3_0906, 18'h3_0907, 18'h3_0a06, 18'h3_0a07};
		fail_count = 0;
		num_checks = 0;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 4; i++) rchk(regs[i], 8'h00);
		for (int k = 0; k < 2; k++) for (int b = 0; b < 4; b++) shp(k, b, 2'h0, 2'h0);
		chk(64'(cfg_ok), 64'h3);
		$display("reset test done");
		// every width code but the reserved one with every count code, all banks alike
		for (int w = 0; w < 3; w++) begin
			for (int c = 0; c < 4; c++) begin
				bus(1'b1, regs[1], {4{2'(w)}}, 1'b1);
				bus(1'b1, regs[0], {4{2'(c)}}, 1'b1);
				settle();
				rchk(regs[1], {4{2'(w)}});
				rchk(regs[0], {4{2'(c)}});
				for (int b = 0; b < 4; b++) shp(0, b, 2'(w), 2'(c));
				chk(64'(cfg_ok[0]), 64'h1);
			end
		end
		$display("sweep test done");
		// distinct count field per bank, mixed widths, proves positions and independence
		bus(1'b1, regs[1], 8'h24, 1'b1);
		bus(1'b1, regs[0], 8'he4, 1'b1);
		fifo_addr <= {8{3'h5}};
		settle();
		for (int b = 0; b < 4; b++) shp(0, b, 2'(8'h24 >> (2 * b)), 2'(b));
		chk(64'(cfg_ok[0]), 64'h0);
		$display("field test done");
		// second core has its own pair, first core untouched
		bus(1'b1, regs[3], 8'h55, 1'b1);
		bus(1'b1, regs[2], 8'h5f, 1'b1);
		settle();
		for (int b = 0; b < 4; b++) shp(1, b, 2'h1, 2'(8'h5f >> (2 * b)));
		chk(64'(cfg_ok[1]), 64'h1);
		rchk(regs[1], 8'h24);
		rchk(regs[0], 8'he4);
		$display("core test done");
		// refused writes and the reserved width code
		bus(1'b1, regs[1], 8'h00, 1'b0);
		rchk(regs[1], 8'h24);
		bus(1'b1, 18'h3_0909, 8'h3c, 1'b1);
		rchk(18'h3_0909, 8'h00);
		bus(1'b1, regs[1], 8'hff, 1'b1);
		settle();
		chk({bank_shape[0][0].valid, bank_shape[0][0].data_depth, bank_shape[0][0].ctrl_depth},
			64'h0);
		chk(64'(cfg_ok[0]), 64'h0);
		rchk(18'h3_0908, 8'h00);
		rchk(18'h3_0a08, 8'h01);
		$display("refusal test done");
		tally_and_finish();
	end
endmodule : rx_buffer_partition_config_tb
`default_nettype wire
